// ### sim/fault_trip_source.sv
// stand-in for the inverter fault circuit driving the trip input
`default_nettype none
module fault_trip_source (
    input wire logic clock,
    input wire logic tripReq,
    output logic faultPin
);
    timeunit 1ns;
    timeprecision 1ns;
    // low means fault; a released line is pulled low, so idle drives high
    initial faultPin = 1'b1;
    always @(posedge clock) begin
        faultPin <= !tripReq;
    end
endmodule // fault_trip_source
`default_nettype wire

// ### sim/three_phase_pwm_register_set_checker.sv
// port assertions of the pwm register set
`include "pwm_regs_defines.vh"
`default_nettype none
module three_phase_pwm_register_set_checker (
    input wire logic clock,
    input wire logic reset,
    input wire logic [31:0] address,
    input wire logic readStrobe,
    input wire logic [15:0] readData,
    input wire logic faultPin,
    input wire logic [5:0] gateOut,
    input wire logic cycleSyncPulse
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    chk_trip_gates: assert property (!faultPin |-> gateOut == 6'h3f)
        else $error("gates not off during trip");
    chk_trip_sync: assert property (!faultPin |-> !cycleSyncPulse)
        else $error("sync pulse during trip");
    chk_pin_level: assert property (readStrobe && address == `ADDR_STATUS
        |=> readData[3] == $past(faultPin)) else $error("raw trip level wrong");
    chk_status_rsvd: assert property (readStrobe && address == `ADDR_STATUS
        |=> readData[15:10] == 6'h00 && readData[7:4] == 4'h0
        && readData[2:1] == 2'h0) else $error("status reserved bits set");
    chk_outctl_rsvd: assert property (readStrobe && address == `ADDR_OUTCTL
        |=> readData[15:9] == 7'h00) else $error("output control too wide");
    chk_chop_rsvd: assert property (readStrobe && address == `ADDR_CHOP
        |=> readData[15:10] == 6'h00) else $error("chop register too wide");
    chk_ten_bit: assert property (readStrobe && (address == `ADDR_DEAD
        || address == `ADDR_SYNCW) |=> readData[15:10] == 6'h00)
        else $error("ten bit register too wide");
    chk_unmapped_zero: assert property (readStrobe && (address < `ADDR_STATUS
        || address > `ADDR_IRQMASK) |=> readData == 16'h0000)
        else $error("unmapped read not zero");
endmodule // three_phase_pwm_register_set_checker
bind three_phase_pwm_register_set three_phase_pwm_register_set_checker chk (
    .clock(clock), .reset(reset), .address(address), .readStrobe(readStrobe),
    .readData(readData), .faultPin(faultPin), .gateOut(gateOut),
    .cycleSyncPulse(cycleSyncPulse));
`default_nettype wire

// ### sim/three_phase_pwm_register_set_tb.sv
// self-checking bench of the pwm register set
`include "pwm_regs_defines.vh"
`default_nettype none
module three_phase_pwm_register_set_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [31:0] address = 32'h0;
    logic [15:0] writeData = 16'h0;
    logic writeStrobe = 1'b0;
    logic readStrobe = 1'b0;
    logic tripReq = 1'b0;
    wire logic faultPin;
    wire logic [15:0] readData;
    wire logic [5:0] gateOut;
    wire logic cycleSyncPulse;
    wire logic interrupt;
    int n_mismatch = 0;
    int checks_done = 0;
    int seed = 96686;
    logic [15:0] got;
    logic [15:0] d;
    logic seenLow;
    logic seenSync;
    logic [1:0] dirSeen;
    logic [31:0] regAddr [8] = '{`ADDR_PERIOD, `ADDR_DEAD, `ADDR_CHOP,
        `ADDR_DUTY0, `ADDR_DUTY1, `ADDR_DUTY2, `ADDR_OUTCTL, `ADDR_SYNCW};
    logic [15:0] regMask [8] = '{16'hffff, 16'h03ff, 16'h03ff, 16'hffff,
        16'hffff, 16'hffff, 16'h01ff, 16'h03ff};
    always #25 clock = ~clock;
    three_phase_pwm_register_set uut (.clock(clock), .reset(reset),
        .address(address), .writeData(writeData), .writeStrobe(writeStrobe),
        .readStrobe(readStrobe), .readData(readData), .faultPin(faultPin),
        .gateOut(gateOut), .cycleSyncPulse(cycleSyncPulse),
        .interrupt(interrupt));
    fault_trip_source trip (.clock(clock), .tripReq(tripReq),
        .faultPin(faultPin));
    // ----------------------------------------
    // bus tasks and compare
    // ----------------------------------------
    task automatic wr(input logic [31:0] a, input logic [15:0] v);
        address <= a;
        writeData <= v;
        writeStrobe <= 1'b1;
        @(posedge clock);
        writeStrobe <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd(input logic [31:0] a);
        address <= a;
        readStrobe <= 1'b1;
        @(posedge clock);
        readStrobe <= 1'b0;
        #1 got = readData;
        @(posedge clock);
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h want %h", $time, g, e);
        end
    endtask
    function automatic logic [15:0] kept(input int i, input logic [15:0] v);
        return v & regMask[i];
    endfunction
    // the window starts two periods in, so a pending latch has landed
    task automatic watch();
        seenLow = 1'b0;
        seenSync = 1'b0;
        repeat (140) @(posedge clock);
        repeat (70) begin
            @(posedge clock);
            #1 seenLow = seenLow | ~&gateOut;
            seenSync = seenSync | cycleSyncPulse;
        end
        @(posedge clock);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        for (int i = 0; i < 8; i++) begin
            rd(regAddr[i]);
            chk(got, 16'h0000);
        end
        rd(`ADDR_STATUS);
        chk(got & 16'hfc0e, 16'h0008);
        $display("reset values done");
        for (int k = 0; k < 4; k++) begin
            for (int i = 0; i < 8; i++) begin
                d = (k == 0) ? 16'hffff : 16'($random(seed));
                wr(regAddr[i], d);
                rd(regAddr[i]);
                chk(got, kept(i, d));
            end
        end
        wr(32'hfffffc2c, 16'hffff);
        rd(32'hfffffc2c);
        chk(got, 16'h0000);
        $display("readback done");
        wr(`ADDR_IRQMASK, 16'h0100);
        chk({15'h0, interrupt}, 16'h0000);
        tripReq <= 1'b1;
        repeat (8) @(posedge clock);
        #1 chk({10'h0, gateOut}, 16'h003f);
        chk({15'h0, interrupt}, 16'h0001);
        @(posedge clock);
        rd(`ADDR_STATUS);
        chk(got & 16'h0108, 16'h0100);
        wr(`ADDR_IRQMASK, 16'h0000);
        chk({15'h0, interrupt}, 16'h0000);
        tripReq <= 1'b0;
        repeat (8) @(posedge clock);
        wr(`ADDR_PERIOD, 16'h0040);
        wr(`ADDR_STATUS, 16'h0100);
        rd(`ADDR_STATUS);
        chk(got & 16'h0108, 16'h0008);
        $display("trip done");
        wr(`ADDR_CHOP, 16'h0000);
        // random dead time left over could swallow every on interval
        wr(`ADDR_DEAD, 16'h0002);
        for (int i = 3; i < 6; i++) wr(regAddr[i], 16'h0020);
        wr(`ADDR_SYNCW, 16'h0004);
        wr(`ADDR_OUTCTL, 16'h003f);
        watch();
        chk({14'h0, seenLow, seenSync}, 16'h0001);
        wr(`ADDR_OUTCTL, 16'h0000);
        watch();
        chk({15'h0, seenLow}, 16'h0001);
        dirSeen = 2'b00;
        repeat (40) begin
            rd(`ADDR_STATUS);
            dirSeen = dirSeen | {got[0], ~got[0]};
        end
        chk({14'h0, dirSeen}, 16'h0003);
        chk(got & 16'h0200, 16'h0200);
        wr(`ADDR_IRQMASK, 16'h0200);
        chk({15'h0, interrupt}, 16'h0001);
        $display("running pwm done");
        summarize();
    end
    initial begin
        repeat (4000) @(posedge clock);
        n_mismatch++;
        summarize();
    end
endmodule // three_phase_pwm_register_set_tb
`default_nettype wire

// ### verilog/pwm_regs_defines.vh
// register offsets, field positions and timing counts of the pwm register set
`ifndef PWM_REGS_DEFINES_VH
`define PWM_REGS_DEFINES_VH
`define ADDR_STATUS 32'hfffffc04
`define ADDR_PERIOD 32'hfffffc08
`define ADDR_DEAD 32'hfffffc0c
`define ADDR_CHOP 32'hfffffc10
`define ADDR_DUTY0 32'hfffffc14
`define ADDR_DUTY1 32'hfffffc18
`define ADDR_DUTY2 32'hfffffc1c
`define ADDR_OUTCTL 32'hfffffc20
`define ADDR_SYNCW 32'hfffffc24
`define ADDR_IRQMASK 32'hfffffc28
`define RESET_VALUE 16'h0000
`define STA_SYNC_IRQ 9
`define STA_FAULT_IRQ 8
`define STA_FAULT_PIN 3
`define STA_DIR 0
`define CHOP_LO_BIT 9
`define CHOP_HI_BIT 8
`define CHOP_MASK 16'h03ff
`define OUTCTL_MASK 16'h01ff
`define STATUS_W1C_MASK 16'h0300
`define TEN_BIT_MASK 16'h03ff
`define CHOP_MULT 10'h004
`endif

// ### verilog/three_phase_pwm_register_set.v
// three-phase six-output pwm generator with its register set
// Function
// - status bit 9 flags sync interrupt
// - status bit 8 flags trip interrupt
// - status bit 3 shows raw trip pin
// - status bit 0 high while counting down
// - chop register: side enables, 8-bit period
// - output control bits 8..6 swap phase pairs
// - output control bits 5..0 disable outputs
// - 16-bit switching period register
// - 10-bit dead time register
// - 10-bit sync pulse width register
// - three per-phase duty registers
// - bit 8 chops high, bit 9 low
// - chop period four times value plus one
// - trip low forces outputs high, stops sync
// - output control latched at cycle start
//
// Local design decision: the address-and-strobe port.
`include "pwm_regs_defines.vh"
`default_nettype none
module three_phase_pwm_register_set (
    input wire clock,
    input wire reset,
    input wire [31:0] address,
    input wire [15:0] writeData,
    input wire writeStrobe,
    input wire readStrobe,
    output reg [15:0] readData,
    input wire faultPin,
    output wire [5:0] gateOut,
    output wire cycleSyncPulse,
    output wire interrupt
);
    // -----------------------------------------------------------------
    // registers
    // -----------------------------------------------------------------
    reg [15:0] periodQ;
    reg [9:0] deadQ;
    reg [9:0] chopQ;
    reg [15:0] duty0Q;
    reg [15:0] duty1Q;
    reg [15:0] duty2Q;
    reg [8:0] outCtlQ;
    reg [8:0] outCtlLiveQ;
    reg [9:0] syncWidthQ;
    reg [1:0] irqFlagQ;
    reg [1:0] irqMaskQ;
    reg [2:0] faultSyncQ;
    reg faultStableQ;
    reg tripQ;
    reg [15:0] countQ;
    reg dirDownQ;
    reg [9:0] syncCountQ;
    reg [9:0] chopCountQ;
    reg chopPhaseQ;
    wire [5:0] gateQ;
    wire [15:0] statusWord;
    wire cycleStart;
    wire [47:0] dutyBus;
    wire [9:0] chopLimit;
    wire wrFlags;
    assign dutyBus = {duty2Q, duty1Q, duty0Q};
    // a level sync at the pin is too slow for safety; trip also gates outputs
    assign statusWord = {6'h00, irqFlagQ, 4'h0, faultPin, 2'h0, dirDownQ};
    assign chopLimit = (`CHOP_MULT * ({2'h0, chopQ[7:0]} + 10'h001)) - 10'h001;
    assign wrFlags = writeStrobe && (address == `ADDR_STATUS);
    // -----------------------------------------------------------------
    // register bus
    // -----------------------------------------------------------------
    always @(posedge clock) begin
        if (reset) begin
            periodQ <= `RESET_VALUE;
            deadQ <= 10'h000;
            chopQ <= 10'h000;
            duty0Q <= `RESET_VALUE;
            duty1Q <= `RESET_VALUE;
            duty2Q <= `RESET_VALUE;
            outCtlQ <= 9'h000;
            syncWidthQ <= 10'h000;
            irqMaskQ <= 2'h0;
            readData <= `RESET_VALUE;
        end else begin
            readData <= 16'h0000;
            if (writeStrobe) begin
                case (address)
                    `ADDR_PERIOD: periodQ <= writeData;
                    `ADDR_DEAD: deadQ <= writeData[9:0];
                    `ADDR_CHOP: chopQ <= writeData[9:0];
                    `ADDR_DUTY0: duty0Q <= writeData;
                    `ADDR_DUTY1: duty1Q <= writeData;
                    `ADDR_DUTY2: duty2Q <= writeData;
                    `ADDR_OUTCTL: outCtlQ <= writeData[8:0];
                    `ADDR_SYNCW: syncWidthQ <= writeData[9:0];
                    `ADDR_IRQMASK: irqMaskQ <= writeData[9:8];
                    default: ;
                endcase
            end
            if (readStrobe) begin
                case (address)
                    `ADDR_STATUS: readData <= statusWord;
                    `ADDR_PERIOD: readData <= periodQ;
                    `ADDR_DEAD: readData <= {6'h00, deadQ};
                    `ADDR_CHOP: readData <= {6'h00, chopQ};
                    `ADDR_DUTY0: readData <= duty0Q;
                    `ADDR_DUTY1: readData <= duty1Q;
                    `ADDR_DUTY2: readData <= duty2Q;
                    `ADDR_OUTCTL: readData <= {7'h00, outCtlQ};
                    `ADDR_SYNCW: readData <= {6'h00, syncWidthQ};
                    `ADDR_IRQMASK: readData <= {6'h00, irqMaskQ, 8'h00};
                    default: readData <= 16'h0000;
                endcase
            end
        end
    end
    // -----------------------------------------------------------------
    // trip input filter and trip state
    // -----------------------------------------------------------------
    always @(posedge clock) begin
        if (reset) begin
            faultSyncQ <= 3'h7;
            faultStableQ <= 1'b1;
            tripQ <= 1'b0;
        end else begin
            faultSyncQ <= {faultSyncQ[1:0], faultPin};
            if (faultSyncQ[2] == faultSyncQ[1]) begin
                faultStableQ <= faultSyncQ[2];
            end
            // timing halts until software rewrites the period register
            if (!faultStableQ) begin
                tripQ <= 1'b1;
            end else if (writeStrobe && address == `ADDR_PERIOD) begin
                tripQ <= 1'b0;
            end
        end
    end
    // -----------------------------------------------------------------
    // center-aligned counter and sync pulse
    // -----------------------------------------------------------------
    assign cycleStart = !tripQ && dirDownQ && (countQ <= 16'h0001);
    always @(posedge clock) begin
        if (reset) begin
            countQ <= 16'h0000;
            dirDownQ <= 1'b1;
            syncCountQ <= 10'h000;
            outCtlLiveQ <= 9'h000;
        end else if (tripQ || !faultStableQ) begin
            countQ <= 16'h0000;
            dirDownQ <= 1'b1;
            syncCountQ <= 10'h000;
        end else begin
            if (dirDownQ) begin
                if (countQ <= 16'h0001) begin
                    dirDownQ <= 1'b0;
                    countQ <= 16'h0000;
                end else begin
                    countQ <= countQ - 16'h0001;
                end
            end else if (countQ >= {1'b0, periodQ[15:1]}) begin
                dirDownQ <= 1'b1;
            end else begin
                countQ <= countQ + 16'h0001;
            end
            if (cycleStart) begin
                outCtlLiveQ <= outCtlQ;
                syncCountQ <= syncWidthQ;
            end else if (syncCountQ != 10'h000) begin
                syncCountQ <= syncCountQ - 10'h001;
            end
        end
    end
    assign cycleSyncPulse = (syncCountQ != 10'h000) && faultPin;
    // -----------------------------------------------------------------
    // gate chopping carrier
    // -----------------------------------------------------------------
    always @(posedge clock) begin
        if (reset) begin
            chopCountQ <= 10'h000;
            chopPhaseQ <= 1'b0;
        end else if (chopCountQ >= chopLimit) begin
            chopCountQ <= 10'h000;
            chopPhaseQ <= 1'b0;
        end else begin
            chopCountQ <= chopCountQ + 10'h001;
            if (chopCountQ == {1'b0, chopLimit[9:1]}) begin
                chopPhaseQ <= 1'b1;
            end
        end
    end
    // -----------------------------------------------------------------
    // per-phase output stage, active low
    // -----------------------------------------------------------------
    genvar p;
    generate
        for (p = 0; p < 3; p = p + 1) begin : phase
            wire [15:0] duty;
            wire [15:0] half;
            wire [15:0] dead;
            wire onHigh;
            wire onLow;
            wire hiChop;
            wire loChop;
            wire swap;
            wire hiDis;
            wire loDis;
            // each phase owns its own pair flop, so gateQ has one driver
            reg [1:0] pairQ;
            assign gateQ[2*p+1:2*p] = pairQ;
            assign duty = dutyBus[16*p+15:16*p];
            assign half = {1'b0, duty[15:1]};
            assign dead = {6'h00, deadQ};
            // dead time trims both sides of each on interval
            assign onHigh = (countQ + dead) < half;
            assign onLow = countQ > (half + dead);
            assign hiChop = onHigh && !(chopQ[`CHOP_HI_BIT] && chopPhaseQ);
            assign loChop = onLow && !(chopQ[`CHOP_LO_BIT] && chopPhaseQ);
            assign swap = outCtlLiveQ[8-p];
            assign loDis = outCtlLiveQ[5-2*p];
            assign hiDis = outCtlLiveQ[4-2*p];
            always @(posedge clock) begin
                if (reset) begin
                    pairQ <= 2'h3;
                end else begin
                    pairQ[1] <= !((swap ? loChop : hiChop) && !hiDis);
                    pairQ[0] <= !((swap ? hiChop : loChop) && !loDis);
                end
            end
        end
    endgenerate
    // trip acts at once on the pin, bypassing the clock
    assign gateOut = (faultPin && !tripQ) ? gateQ : 6'h3f;
    // -----------------------------------------------------------------
    // interrupt flags, set wins over write-one clear
    // -----------------------------------------------------------------
    always @(posedge clock) begin
        if (reset) begin
            irqFlagQ <= 2'h0;
        end else begin
            irqFlagQ[1] <= (cycleStart && faultStableQ) ||
                (irqFlagQ[1] && !(wrFlags && writeData[`STA_SYNC_IRQ]));
            irqFlagQ[0] <= (!faultStableQ && !tripQ) ||
                (irqFlagQ[0] && !(wrFlags && writeData[`STA_FAULT_IRQ]));
        end
    end
    assign interrupt = |(irqFlagQ & irqMaskQ);
endmodule // three_phase_pwm_register_set
`default_nettype wire
